// *** rail_mask_pkg.sv ***
// Constants, encodings and reset tables for the rail mask bank
// Operation
// - First fault mask: bit7 mid ldo two, bit6 switch a, bits5..0 bucks 6..1
// - Mask 0 lets a rail fault shut down; mask 1 ignores it
// - Step-down rails 1 to 6 masks sit at bits 0 to 5, own rail only
// - Fault masks load a factory option dependent pattern at reset
// - Second fault mask: bits 0..4 ldo three, switch b1, b2, termination, ldo one
// - Set ldo one mask blocks its fault; clear lets it shut down
// - Tree mask 0 includes that rail's power good in output one tree
// - Tree mask 1 removes that rail from the output one tree
// - Tree layout: bucks 1..6 bits 0..5, switch a bit 6, ldo two bit 7
package rail_mask_pkg;

	//--------------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------------
	localparam logic [7:0] FAULT_ONE_OFFSET  = 8'ha2;
	localparam logic [7:0] FAULT_TWO_OFFSET  = 8'ha3;
	localparam logic [7:0] TREE_ONE_OFFSET   = 8'ha4;

	// Field positions
	localparam int STEP_DOWN_1_BIT       = 0;
	localparam int STEP_DOWN_6_BIT       = 5;
	localparam int SWITCH_A_BIT          = 6;
	localparam int LDO_TWO_BIT           = 7;
	localparam int LDO_THREE_BIT         = 0;
	localparam int SWITCH_B_FIRST_BIT    = 1;
	localparam int SWITCH_B_SECOND_BIT   = 2;
	localparam int TERMINATION_BIT       = 3;
	localparam int LDO_ONE_BIT           = 4;
	localparam int RESV_ONE_BIT          = 5;
	localparam int RESV_ZERO_BIT         = 6;
	localparam int FAULT_TWO_RO_BIT      = 7;

	// Rail counts: first register eight rails, second five
	localparam int FAULT_RAILS           = 13;
	localparam int TREE_RAILS            = 8;

	// Writable bits of the second fault mask
	localparam logic [7:0] FAULT_TWO_WMASK = 8'h7f;

	//--------------------------------------------------------------------
	// Factory option reset tables, option 0 in the low byte
	//--------------------------------------------------------------------
	localparam logic [31:0] FAULT_ONE_RESETS = 32'hc0_40_00_c0;
	localparam logic [31:0] FAULT_TWO_RESETS = 32'h37_20_28_27;
	localparam logic [31:0] TREE_ONE_RESETS  = 32'hfc_fe_5c_fd;

	//--------------------------------------------------------------------
	// Two-wire slave
	//--------------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_PTR       = 4'b0011,
		ST_PTR_ACK   = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} link_state_t;

	// Pick one option's byte out of a packed reset table
	function automatic logic [7:0] option_reset(
		input logic [31:0] table_bits,
		input logic [1:0]  option
	);
		option_reset = table_bits[{option, 3'h0} +: 8];
	endfunction

endpackage

// *** rail_mask_if.sv ***
// Bundle between the register bank and the mask gating logic
`timescale 1ns/10ps
`default_nettype none
interface rail_mask_if;
	import rail_mask_pkg::*;

	logic [FAULT_RAILS-1:0] fault_mask;
	logic [TREE_RAILS-1:0]  tree_mask;
	logic [FAULT_RAILS-1:0] fault;
	logic [TREE_RAILS-1:0]  good;
	logic                   shutdown;
	logic                   tree_good;

	modport bank (
		output fault_mask,
		output tree_mask,
		output fault,
		output good,
		input  shutdown,
		input  tree_good
	);

	modport gate (
		input  fault_mask,
		input  tree_mask,
		input  fault,
		input  good,
		output shutdown,
		output tree_good
	);
endinterface
`default_nettype wire

// *** rail_mask_gate.sv ***
// Fault shutdown gating and output one power good tree
`timescale 1ns/10ps
`default_nettype none
module rail_mask_gate
	import rail_mask_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	rail_mask_if.gate masks
);

	//--------------------------------------------------------------------
	// Per rail gating
	//--------------------------------------------------------------------
	wire [FAULT_RAILS-1:0] fault_kept;
	wire [TREE_RAILS-1:0]  good_kept;

	genvar rail;
	generate
		// A masked rail can neither trip nor hold the tree low
		for (rail = 0; rail < FAULT_RAILS; rail++) begin : g_fault
			assign fault_kept[rail] = masks.fault[rail] &
				~masks.fault_mask[rail];
		end
		for (rail = 0; rail < TREE_RAILS; rail++) begin : g_tree
			assign good_kept[rail] = masks.good[rail] |
				masks.tree_mask[rail];
		end
	endgenerate

	wire shutdown_next  = |fault_kept;
	wire tree_good_next = &good_kept;

	//--------------------------------------------------------------------
	// Registered results, one cycle behind the inputs
	//--------------------------------------------------------------------
	logic shutdown_reg;
	logic tree_good_reg;

	// Reset holds shutdown off and power good low until sampled
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			shutdown_reg  <= 1'b0;
			tree_good_reg <= 1'b0;
		end else begin
			shutdown_reg  <= shutdown_next;
			tree_good_reg <= tree_good_next;
		end
	end

	assign masks.shutdown  = shutdown_reg;
	assign masks.tree_good = tree_good_reg;

endmodule
`default_nettype wire

// *** rail_mask_bank.sv ***
// Rail fault and power good tree mask registers behind a two-wire slave
`timescale 1ns/10ps
`default_nettype none
module rail_mask_bank
	import rail_mask_pkg::*;
#(
	// Factory option, 0 to 3, selects the reset patterns
	parameter logic [1:0] OPTION      = 2'h0,
	// Seven bit bus address; the value is arbitrary
	parameter logic [6:0] DEVICE_ADDR = 7'h2a
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_scl,
	input  wire logic                   i_sda,
	output logic                        o_sda,
	output logic                        o_sda_oe,
	input  wire logic [FAULT_RAILS-1:0] i_rail_fault,
	input  wire logic [TREE_RAILS-1:0]  i_rail_good,
	output logic                        o_shutdown,
	output logic                        o_general_output_one_good
);

	//--------------------------------------------------------------------
	// Reset patterns for the chosen option
	//--------------------------------------------------------------------
	localparam logic [7:0] FAULT_ONE_INIT =
		option_reset(FAULT_ONE_RESETS, OPTION);
	localparam logic [7:0] FAULT_TWO_INIT =
		option_reset(FAULT_TWO_RESETS, OPTION) & FAULT_TWO_WMASK;
	localparam logic [7:0] TREE_ONE_INIT =
		option_reset(TREE_ONE_RESETS, OPTION);

	//--------------------------------------------------------------------
	// Storage
	//--------------------------------------------------------------------
	logic [7:0]  fault_one_reg;
	logic [7:0]  fault_two_reg;
	logic [7:0]  tree_one_reg;
	logic        scl_reg;
	logic        sda_reg;
	logic        scl_prev_reg;
	logic        sda_prev_reg;
	link_state_t state_reg;
	link_state_t state_next;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  ptr_reg;
	logic        read_reg;
	logic        nack_reg;

	// Read side of the register map; unmapped offsets read zero
	function automatic logic [7:0] read_mux(
		input logic [7:0] offset,
		input logic [7:0] fault_one,
		input logic [7:0] fault_two,
		input logic [7:0] tree_one
	);
		case (offset)
			FAULT_ONE_OFFSET: read_mux = fault_one;
			FAULT_TWO_OFFSET: read_mux = fault_two & FAULT_TWO_WMASK;
			TREE_ONE_OFFSET:  read_mux = tree_one;
			default:          read_mux = 8'h00;
		endcase
	endfunction

	//--------------------------------------------------------------------
	// Bus condition decode
	//--------------------------------------------------------------------
	wire scl_rise   = scl_reg & ~scl_prev_reg;
	wire scl_fall   = ~scl_reg & scl_prev_reg;
	wire bus_start  = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
	wire bus_stop   = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
	wire byte_done  = (bit_cnt_reg == BITS_PER_BYTE);
	wire addr_hit   = (shift_reg[7:1] == DEVICE_ADDR);
	wire receiving  = (state_reg == ST_ADDR) || (state_reg == ST_PTR) ||
		(state_reg == ST_WDATA);
	wire write_now  = scl_fall && byte_done && (state_reg == ST_WDATA);
	wire [7:0] rd_byte = read_mux(ptr_reg, fault_one_reg, fault_two_reg,
		tree_one_reg);
	wire [7:0] ptr_inc = ptr_reg + 8'h01;

	//--------------------------------------------------------------------
	// Link state sequencing
	//--------------------------------------------------------------------
	// Start wins anywhere so a repeated start restarts the address phase
	always_comb begin
		state_next = state_reg;
		if (bus_start) begin
			state_next = ST_ADDR;
		end else if (bus_stop) begin
			state_next = ST_IDLE;
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (byte_done) begin
						state_next = addr_hit ? ST_ADDR_ACK : ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					state_next = read_reg ? ST_RDATA : ST_PTR;
				end
				ST_PTR: begin
					if (byte_done) begin
						state_next = ST_PTR_ACK;
					end
				end
				ST_PTR_ACK: begin
					state_next = ST_WDATA;
				end
				ST_WDATA: begin
					if (byte_done) begin
						state_next = ST_WDATA_ACK;
					end
				end
				ST_WDATA_ACK: begin
					state_next = ST_WDATA;
				end
				ST_RDATA: begin
					if (byte_done) begin
						state_next = ST_RDATA_ACK;
					end
				end
				ST_RDATA_ACK: begin
					state_next = nack_reg ? ST_IDLE : ST_RDATA;
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// Pins are taken as synchronous; one stage gives the edge history
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			state_reg    <= ST_IDLE;
		end else begin
			scl_reg      <= i_scl;
			sda_reg      <= i_sda;
			scl_prev_reg <= scl_reg;
			sda_prev_reg <= sda_reg;
			state_reg    <= state_next;
		end
	end

	//--------------------------------------------------------------------
	// Bit counting and shifting
	//--------------------------------------------------------------------
	// Bits are sampled on SCL rise and the count clears as a byte closes
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			read_reg    <= 1'b0;
			nack_reg    <= 1'b0;
		end else if (bus_start) begin
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise) begin
			if (receiving) begin
				shift_reg <= {shift_reg[6:0], sda_reg};
			end
			if (receiving || state_reg == ST_RDATA) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (state_reg == ST_RDATA_ACK) begin
				nack_reg <= sda_reg;
			end
		end else if (scl_fall && byte_done) begin
			bit_cnt_reg <= 4'h0;
			if (state_reg == ST_ADDR) begin
				read_reg <= shift_reg[0];
			end
		end
	end

	//--------------------------------------------------------------------
	// Pointer and transmit byte
	//--------------------------------------------------------------------
	// The pointer steps after each data byte so bursts walk the map
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ptr_reg <= 8'h00;
			tx_reg  <= 8'h00;
		end else if (scl_fall) begin
			if (state_reg == ST_PTR && byte_done) begin
				ptr_reg <= shift_reg;
			end else if (write_now) begin
				ptr_reg <= ptr_inc;
			end else if ((state_reg == ST_ADDR_ACK && read_reg) ||
					(state_reg == ST_RDATA_ACK && !nack_reg)) begin
				tx_reg  <= rd_byte;
				ptr_reg <= ptr_inc;
			end else if (state_reg == ST_RDATA && !byte_done) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	//--------------------------------------------------------------------
	// Mask registers
	//--------------------------------------------------------------------
	// Reserved bits 6 and 5 are stored as written; keeping them at 0 and
	// 1 is left to the host, bit 7 never stores
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			fault_one_reg <= FAULT_ONE_INIT;
			fault_two_reg <= FAULT_TWO_INIT;
			tree_one_reg  <= TREE_ONE_INIT;
		end else if (write_now) begin
			case (ptr_reg)
				FAULT_ONE_OFFSET: fault_one_reg <= shift_reg;
				FAULT_TWO_OFFSET:
					fault_two_reg <= shift_reg & FAULT_TWO_WMASK;
				TREE_ONE_OFFSET:  tree_one_reg  <= shift_reg;
				default:          fault_one_reg <= fault_one_reg;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// Open-drain data pin
	//--------------------------------------------------------------------
	// Only ever pulls low; a one is sent by releasing the line
	assign o_sda    = 1'b0;
	assign o_sda_oe = (state_reg == ST_ADDR_ACK) ||
		(state_reg == ST_PTR_ACK) || (state_reg == ST_WDATA_ACK) ||
		(state_reg == ST_RDATA && !tx_reg[7]);

	//--------------------------------------------------------------------
	// Mask gating
	//--------------------------------------------------------------------
	rail_mask_if masks ();

	// Fault order: first register bits 7..0, then second bits 4..0
	assign masks.fault_mask = {fault_two_reg[LDO_ONE_BIT:LDO_THREE_BIT],
		fault_one_reg};
	assign masks.tree_mask  = tree_one_reg;
	assign masks.fault      = i_rail_fault;
	assign masks.good       = i_rail_good;

	rail_mask_gate u_gate (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.masks   (masks.gate)
	);

	assign o_shutdown                = masks.shutdown;
	assign o_general_output_one_good = masks.tree_good;

endmodule
`default_nettype wire

// *** rail_mask_props.sv ***
// Port level assertions for the rail mask bank
`timescale 1ns/10ps
`default_nettype none
module rail_mask_props
	import rail_mask_pkg::*;
#(
	parameter logic [1:0] OPTION = 2'h0
) (
	input wire logic                   i_clock,
	input wire logic                   i_rst_n,
	input wire logic                   i_scl,
	input wire logic                   i_sda,
	input wire logic                   o_sda,
	input wire logic                   o_sda_oe,
	input wire logic [FAULT_RAILS-1:0] i_rail_fault,
	input wire logic [TREE_RAILS-1:0]  i_rail_good,
	input wire logic                   o_shutdown,
	input wire logic                   o_general_output_one_good
);
	//--------------------------------------------------------------------
	// Reset patterns, option 0 lowest
	//--------------------------------------------------------------------
	localparam logic [31:0] F1_TAB = 32'hc0_40_00_c0;
	localparam logic [31:0] F2_TAB = 32'h37_20_28_27;
	localparam logic [31:0] T1_TAB = 32'hfc_fe_5c_fd;
	localparam logic [7:0]  RST_F2 = F2_TAB[{OPTION, 3'h0} +: 8];
	localparam logic [12:0] RST_FAULT =
		{RST_F2[4:0], F1_TAB[{OPTION, 3'h0} +: 8]};
	localparam logic [7:0]  RST_TREE = T1_TAB[{OPTION, 3'h0} +: 8];

	// Edges since release; no bus write can land this early
	logic [5:0] settle_cnt;
	wire logic  early;
	assign early = settle_cnt > 6'h03 && settle_cnt < 6'h28;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n)
			settle_cnt <= 6'h00;
		else if (settle_cnt != 6'h3f)
			settle_cnt <= settle_cnt + 6'h01;
	end

	//--------------------------------------------------------------------
	// Properties
	//--------------------------------------------------------------------
	sequence s_settled;
		i_rst_n [*3];
	endsequence
	property p_sda_zero;
		@(posedge i_clock) disable iff (!i_rst_n) o_sda == 1'b0;
	endproperty
	property p_rst_quiet;
		@(posedge i_clock) !i_rst_n |=>
			!o_shutdown && !o_general_output_one_good && !o_sda_oe;
	endproperty
	property p_no_fault;
		@(posedge i_clock) disable iff (!i_rst_n)
			s_settled ##0 (i_rail_fault == '0) |=> !o_shutdown;
	endproperty
	property p_all_good;
		@(posedge i_clock) disable iff (!i_rst_n)
			s_settled ##0 (&i_rail_good) |=> o_general_output_one_good;
	endproperty
	property p_shut_cause;
		@(posedge i_clock) disable iff (!i_rst_n)
			$rose(o_shutdown) |-> $past(i_rail_fault) != '0;
	endproperty
	property p_good_cause;
		@(posedge i_clock) disable iff (!i_rst_n)
			$past(i_rst_n) && $fell(o_general_output_one_good)
			|-> !(&$past(i_rail_good));
	endproperty
	property p_oe_stable;
		@(posedge i_clock) disable iff (!i_rst_n)
			i_scl && $past(i_scl) && $past(i_scl, 2) |-> $stable(o_sda_oe);
	endproperty
	property p_reset_shut;
		@(posedge i_clock) disable iff (!i_rst_n)
			early |-> o_shutdown == |($past(i_rail_fault) & ~RST_FAULT);
	endproperty
	property p_reset_tree;
		@(posedge i_clock) disable iff (!i_rst_n)
			early |-> o_general_output_one_good ==
				&($past(i_rail_good) | RST_TREE);
	endproperty

	a_sda_zero: assert property (p_sda_zero)
		else $error("sda drive value not low");
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active during reset");
	a_no_fault: assert property (p_no_fault)
		else $error("shutdown without any fault");
	a_all_good: assert property (p_all_good)
		else $error("tree low with all rails good");
	a_shut_cause: assert property (p_shut_cause)
		else $error("shutdown rose without fault");
	a_good_cause: assert property (p_good_cause)
		else $error("tree fell with all rails good");
	a_oe_stable: assert property (p_oe_stable)
		else $error("sda drive changed while scl high");
	a_reset_shut: assert property (p_reset_shut)
		else $error("shutdown wrong for reset masks");
	a_reset_tree: assert property (p_reset_tree)
		else $error("tree wrong for reset masks");
endmodule

bind rail_mask_bank rail_mask_props #(.OPTION(OPTION)) i_rail_mask_props (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_scl(i_scl),
	.i_sda(i_sda),
	.o_sda(o_sda),
	.o_sda_oe(o_sda_oe),
	.i_rail_fault(i_rail_fault),
	.i_rail_good(i_rail_good),
	.o_shutdown(o_shutdown),
	.o_general_output_one_good(o_general_output_one_good)
);
`default_nettype wire

// *** rail_host_model.sv ***
// Two-wire host model that writes and reads the mask registers
`timescale 1ns/10ps
`default_nettype none
module rail_host_model
	import rail_mask_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	// Bus idles released; the pull-up gives the high level
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Quarter bit: keeps both scl phases at six clocks
	task automatic q();
		repeat (3) @(negedge i_clock);
	endtask
	task automatic start();
		o_sda_low = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda_low = 1'b1;
		q();
		o_scl = 1'b0;
		q();
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda_low = 1'b0;
		q();
	endtask
	task automatic put_bit(input logic b, output logic r);
		o_sda_low = !b;
		q();
		o_scl = 1'b1;
		q();
		r = i_sda;
		q();
		o_scl = 1'b0;
		q();
	endtask
	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			put_bit(tx[i], rx[i]);
		put_bit(ack_in, ack);
	endtask

	task automatic write_reg(input logic [6:0] addr, input logic [7:0] off,
		input logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic [7:0] d;
		logic       a0;
		logic       a1;
		logic       a2;
		d = data;
		if (off == FAULT_TWO_OFFSET)
			d = (d & 8'hbf) | 8'h20;
		start();
		xfer({addr, 1'b0}, 1'b1, rx, a0);
		xfer(off, 1'b1, rx, a1);
		xfer(d, 1'b1, rx, a2);
		stop();
		ok = !(a0 || a1 || a2);
	endtask
	task automatic read_reg(input logic [6:0] addr, input logic [7:0] off,
		output logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       nack;
		start();
		xfer({addr, 1'b0}, 1'b1, rx, a0);
		xfer(off, 1'b1, rx, a1);
		start();
		xfer({addr, 1'b1}, 1'b1, rx, a2);
		xfer(8'hff, 1'b1, data, nack);
		stop();
		ok = !(a0 || a1 || a2);
	endtask
endmodule
`default_nettype wire

// *** test_rail_mask_bank.sv ***
// Randomised self-checking bench for the rail mask bank
`timescale 1ns/10ps
`default_nettype none
module test_rail_mask_bank;
	import rail_mask_pkg::*;

	localparam logic [1:0]  OPT  = 2'h2;
	localparam logic [6:0]  ADDR = 7'h2a; // Arbitrary bus address
	localparam logic [95:0] TAB  = 96'hfcfe5cfd_37202827_c04000c0;

	logic        clock;
	logic        rst_n;
	logic        scl;
	logic        host_low;
	logic        sda_oe;
	logic        sda_val;
	logic [12:0] fault;
	logic [7:0]  good;
	logic        shut;
	logic        pg;
	logic        ok;
	logic [7:0]  m1;
	logic [7:0]  m2;
	logic [7:0]  t1;
	int          miscompares;
	int          num_checks;
	wire logic   sda;

	// Open drain wire with a pull-up
	assign sda = !(host_low || sda_oe);
	always #25 clock = ~clock;

	rail_mask_bank #(.OPTION(OPT), .DEVICE_ADDR(ADDR)) i_rail_mask_bank (
		.i_clock(clock),
		.i_rst_n(rst_n),
		.i_scl(scl),
		.i_sda(sda),
		.o_sda(sda_val),
		.o_sda_oe(sda_oe),
		.i_rail_fault(fault),
		.i_rail_good(good),
		.o_shutdown(shut),
		.o_general_output_one_good(pg)
	);
	rail_host_model i_rail_host_model (
		.i_clock(clock),
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_low(host_low)
	);

	//--------------------------------------------------------------------
	// Expectations
	//--------------------------------------------------------------------
	function automatic logic [7:0] reset_of(input int r);
		return TAB[r * 32 + OPT * 8 +: 8];
	endfunction
	function automatic logic exp_shut(input logic [12:0] f);
		return |(f & ~{m2[4:0], m1});
	endfunction
	function automatic logic exp_pg(input logic [7:0] g);
		return &(g | t1);
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	//--------------------------------------------------------------------
	// Bus and rail stimulus
	//--------------------------------------------------------------------
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		i_rail_host_model.write_reg(ADDR, off, d, ok);
		check({7'h0, ok}, 8'h01);
	endtask
	task automatic rd_chk(input logic [7:0] off, input logic [7:0] want);
		logic [7:0] d;
		i_rail_host_model.read_reg(ADDR, off, d, ok);
		check({7'h0, ok}, 8'h01);
		check(d, want);
	endtask
	task automatic set_masks();
		wr(FAULT_ONE_OFFSET, m1);
		wr(FAULT_TWO_OFFSET, m2);
		wr(TREE_ONE_OFFSET, t1);
	endtask
	// One registered stage; three edges leave margin
	task automatic apply(input logic [12:0] f, input logic [7:0] g);
		fault = f;
		good = g;
		repeat (3) @(negedge clock);
		check({7'h0, shut}, {7'h0, exp_shut(f)});
		check({7'h0, pg}, {7'h0, exp_pg(g)});
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		finish_test();
	end

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(80882));
		fault = 13'($urandom);
		good = 8'($urandom);
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		rd_chk(FAULT_ONE_OFFSET, reset_of(0));
		rd_chk(FAULT_TWO_OFFSET, reset_of(1));
		rd_chk(TREE_ONE_OFFSET, reset_of(2));
		$display("test reset values done");
		wr(FAULT_TWO_OFFSET, 8'hdf);
		rd_chk(FAULT_TWO_OFFSET, 8'h3f);
		wr(8'ha5, 8'h5a);
		rd_chk(8'ha5, 8'h00);
		i_rail_host_model.write_reg(ADDR ^ 7'h01, FAULT_ONE_OFFSET, 8'h3c, ok);
		check({7'h0, ok}, 8'h00);
		rd_chk(FAULT_ONE_OFFSET, reset_of(0));
		$display("test access done");
		for (int p = 0; p < 2; p++) begin
			m1 = (p == 1) ? 8'hff : 8'h00;
			m2 = (p == 1) ? 8'h3f : 8'h20;
			t1 = m1;
			set_masks();
			for (int i = 0; i < 13; i++)
				apply(13'h1 << i, (i < 8) ? ~(8'h01 << i) : 8'hff);
			// Quiet rails, all good: the idle case that the checker watches
			apply(13'h0000, 8'hff);
		end
		$display("test rail walk done");
		for (int n = 0; n < 16; n++) begin
			m1 = 8'($urandom);
			m2 = (8'($urandom) & 8'h1f) | 8'h20;
			t1 = 8'($urandom);
			set_masks();
			rd_chk(FAULT_ONE_OFFSET, m1);
			repeat (4) apply(13'($urandom), 8'($urandom | $urandom));
		end
		$display("test random masks done");
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		rd_chk(TREE_ONE_OFFSET, reset_of(2));
		$display("test second reset done");
		finish_test();
	end
endmodule
`default_nettype wire
